// *** design/lsnt_pkg.sv ***
// Shared constants and types for the line state event mask and noise timer block
package lsnt_pkg;

  // Control bus geometry
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;

  // Register addresses on the control bus
  localparam logic [ADDR_W-1:0] ADDR_MASK_A = 5'h0b;
  localparam logic [ADDR_W-1:0] ADDR_MASK_B = 5'h0c;
  localparam logic [ADDR_W-1:0] ADDR_NOISE_START = 5'h0d;
  localparam logic [ADDR_W-1:0] ADDR_PRESCALE_START = 5'h0e;

  // Counter widths
  localparam int NOISE_W = 7;
  localparam int PRE_W = 8;

  // Reset values
  localparam logic [DATA_W-1:0] MASK_RESET = 8'h00;
  localparam logic [NOISE_W-1:0] NOISE_START_RESET = 7'h00;
  localparam logic [PRE_W-1:0] PRESCALE_START_RESET = 8'h00;
  localparam logic [NOISE_W-1:0] NOISE_CNT_RESET = 7'h00;
  localparam logic [PRE_W-1:0] PRE_CNT_RESET = 8'h00;
  localparam logic NOISE_FLAG_RESET = 1'b1;
  localparam logic [DATA_W-1:0] RDATA_UNMAPPED = 8'h00;

  // Bit position of the noise expired flag within condition flags A
  localparam int NOISE_FLAG_BIT = 5;

  // Symbol pair timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int PAIR_PERIOD_NS = 80;
  localparam int PAIR_CYCLES = PAIR_PERIOD_NS / CLK_PERIOD_NS;
  localparam int PAIR_CNT_W = 3;
  localparam logic [PAIR_CNT_W-1:0] PAIR_LAST = PAIR_CNT_W'(PAIR_CYCLES - 1);
  localparam logic [PAIR_CNT_W-1:0] PAIR_CNT_RESET = 3'h0;

  // Current line state classification, one code per state
  typedef enum logic [7:0] {
    LSNT_LS_QUIET   = 8'h01,
    LSNT_LS_HALT    = 8'h02,
    LSNT_LS_MASTER  = 8'h04,
    LSNT_LS_IDLE    = 8'h08,
    LSNT_LS_ACTIVE  = 8'h10,
    LSNT_LS_NOISE   = 8'h20,
    LSNT_LS_UNKNOWN = 8'h40,
    LSNT_LS_NOSIG   = 8'h80
  } lsnt_line_e;

endpackage

// *** design/lsnt_down_counter.sv ***
// Loadable down counter used for the noise and prescale timers
`timescale 1ns/10ps
module lsnt_down_counter #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys, // System clock
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic load, // Load start value, wins over decrement
  input wire logic [WIDTH-1:0] load_val, // Start value
  input wire logic dec, // Decrement by one
  output logic [WIDTH-1:0] count_q // Current count
);

  // Width check
  if (WIDTH < 1 || WIDTH > 16)
  begin : g_bad_width
    $error("lsnt_down_counter: WIDTH out of range");
  end

  // Count register, cleared by reset
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count_q <= '0;
    end
    else if (load)
    begin
      count_q <= load_val;
    end
    else if (dec && count_q != '0)
    begin
      count_q <= count_q - WIDTH'(1);
    end
  end

endmodule

// *** design/lsnt_mask_summary.sv ***
// Masked OR of a condition flag group into one registered summary bit
`timescale 1ns/10ps
module lsnt_mask_summary #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys, // System clock
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic [WIDTH-1:0] flags, // Condition flags
  input wire logic [WIDTH-1:0] mask, // Per-flag enables
  output logic summary_q // Any enabled flag set
);

  // Width check
  if (WIDTH < 1)
  begin : g_bad_width
    $error("lsnt_mask_summary: WIDTH must be positive");
  end

  // Summary follows the masked flags one cycle later
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      summary_q <= 1'b0;
    end
    else
    begin
      summary_q <= |(flags & mask);
    end
  end

endmodule

// *** design/lsnt_top.sv ***
// Receive event masks, noise timer and control bus registers
//
// What this block does
// - Summary A sets when any condition A flag and its mask bit are set.
// - Summary B sets when any condition B flag and its mask bit are set.
// - Reset clears both mask registers, so every event starts masked.
// - Mask A bits 0-7: no signal, quiet, halt, master, noise, expiry, change, unknown.
// - Mask B bits 0-7: idle, state expiry, active, unknown, cascade, buffer, super idle, reserved.
// - In noise-class states noise counter drops once per prescale period.
// - From fresh load, zero is reached after ((P+1)*N+P) symbol pairs.
// - Both counters zero in noise-class state reload both from start values.
// - In quiet-class states both counters are held at their start values.
// - A write to either start register loads both counters at once.
// - Prescale reaching zero with noise nonzero reloads itself and decrements the noise counter once.
// - Changing between noise-class states neither reloads nor resets the counters.
// - Both counters at zero on a tick in a noise-class state set the noise expired flag.
// - Noise start register keeps seven bits; bit 7 reads zero, ignores writes.
// - Prescale start register keeps eight bits; the prescale counter loads them.
// - Noise expired flag holds until a nonzero start value is written.
// - Reset zeroes the noise counter; the expired flag resets to one, so it is set during reset.
`timescale 1ns/10ps
module lsnt_top #(
  parameter int NOISE_W = lsnt_pkg::NOISE_W,
  parameter int PRE_W = lsnt_pkg::PRE_W
) (
  input wire logic clk_sys, // System clock, 100 MHz
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic [lsnt_pkg::ADDR_W-1:0] cb_addr, // Control bus register address
  input wire logic [lsnt_pkg::DATA_W-1:0] cb_wdata, // Control bus write data
  input wire logic cb_wr, // Control bus write strobe, one cycle
  input wire logic cb_rd, // Control bus read strobe, one cycle
  output logic [lsnt_pkg::DATA_W-1:0] cb_rdata, // Read data, valid the cycle after cb_rd
  input wire lsnt_pkg::lsnt_line_e line_state, // Current line state classification
  input wire logic [lsnt_pkg::DATA_W-1:0] receive_condition_flags_a, // Condition A flags, bit 5 unused
  input wire logic [lsnt_pkg::DATA_W-1:0] receive_condition_flags_b, // Condition B flags
  output logic noise_expired_flag, // Noise expired flag, condition A bit 5
  output logic receive_summary_a, // Summary A bit of interrupt condition register
  output logic receive_summary_b, // Summary B bit of interrupt condition register
  output logic [NOISE_W-1:0] noise_count, // Current noise counter
  output logic [PRE_W-1:0] prescale_count, // Current prescale counter
  output logic pair_tick // Symbol pair tick, one cycle in eight
);
  import lsnt_pkg::*;

  // Parameter checks
  if (NOISE_W < 1 || NOISE_W > DATA_W - 1)
  begin : g_bad_noise_w
    $error("lsnt_top: NOISE_W must leave bit 7 reserved");
  end
  if (PRE_W < 1 || PRE_W > DATA_W)
  begin : g_bad_pre_w
    $error("lsnt_top: PRE_W must fit the data bus");
  end

  // Register state
  logic [DATA_W-1:0] mask_a_q;
  logic [DATA_W-1:0] mask_b_q;
  logic [NOISE_W-1:0] noise_start_q;
  logic [PRE_W-1:0] prescale_start_q;
  logic [DATA_W-1:0] rdata_q;
  logic noise_flag_q;
  logic [PAIR_CNT_W-1:0] pair_cnt_q;

  // Decoded strobes and timer controls
  logic wr_mask_a;
  logic wr_mask_b;
  logic wr_noise_start;
  logic wr_prescale_start;
  logic start_write;
  logic flag_clear;
  logic noise_class;
  logic tick;
  logic pre_zero;
  logic noise_zero;
  logic load_both;
  logic pre_reload;
  logic pre_dec;
  logic noise_dec;
  logic flag_set;
  logic [NOISE_W-1:0] noise_cnt;
  logic [PRE_W-1:0] pre_cnt;
  logic [DATA_W-1:0] flags_a_eff;
  logic [NOISE_W-1:0] noise_start_d;
  logic [PRE_W-1:0] prescale_start_d;

  // Write decode
  assign wr_mask_a = cb_wr && (cb_addr == ADDR_MASK_A);
  assign wr_mask_b = cb_wr && (cb_addr == ADDR_MASK_B);
  assign wr_noise_start = cb_wr && (cb_addr == ADDR_NOISE_START);
  assign wr_prescale_start = cb_wr && (cb_addr == ADDR_PRESCALE_START);
  assign start_write = wr_noise_start || wr_prescale_start;

  // Start values as they stand after this edge, so a write loads the new value
  assign noise_start_d = wr_noise_start ? cb_wdata[NOISE_W-1:0] : noise_start_q;
  assign prescale_start_d = wr_prescale_start ? cb_wdata[PRE_W-1:0] : prescale_start_q;

  // Only a nonzero start value releases the expired flag
  assign flag_clear = (wr_noise_start && (cb_wdata[NOISE_W-1:0] != '0)) ||
                      (wr_prescale_start && (cb_wdata[PRE_W-1:0] != '0));

  // Mask registers; enables laid out as condition flags A and B
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mask_a_q <= MASK_RESET;
      mask_b_q <= MASK_RESET;
    end
    else
    begin
      if (wr_mask_a)
      begin
        mask_a_q <= cb_wdata;
      end
      if (wr_mask_b)
      begin
        mask_b_q <= cb_wdata;
      end
    end
  end

  // Start value registers; noise start drops bit 7 of write data
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      noise_start_q <= NOISE_START_RESET;
      prescale_start_q <= PRESCALE_START_RESET;
    end
    else
    begin
      if (wr_noise_start)
      begin
        noise_start_q <= cb_wdata[NOISE_W-1:0];
      end
      if (wr_prescale_start)
      begin
        prescale_start_q <= cb_wdata[PRE_W-1:0];
      end
    end
  end

  // Read data; unmapped addresses read zero, unused upper bits read zero
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdata_q <= RDATA_UNMAPPED;
    end
    else if (cb_rd)
    begin
      unique case (cb_addr)
        ADDR_MASK_A: rdata_q <= mask_a_q;
        ADDR_MASK_B: rdata_q <= mask_b_q;
        ADDR_NOISE_START: rdata_q <= DATA_W'(noise_start_q);
        ADDR_PRESCALE_START: rdata_q <= DATA_W'(prescale_start_q);
        default: rdata_q <= RDATA_UNMAPPED;
      endcase
    end
  end
  assign cb_rdata = rdata_q;

  // Symbol pair divider, one tick every 80 ns
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pair_cnt_q <= PAIR_CNT_RESET;
    end
    else if (pair_cnt_q == PAIR_LAST)
    begin
      pair_cnt_q <= PAIR_CNT_RESET;
    end
    else
    begin
      pair_cnt_q <= pair_cnt_q + PAIR_CNT_W'(1);
    end
  end
  assign tick = (pair_cnt_q == PAIR_LAST);
  assign pair_tick = tick;

  // Noise, active and unknown keep the timer running; all else holds it loaded
  assign noise_class = (line_state == LSNT_LS_NOISE) ||
                       (line_state == LSNT_LS_ACTIVE) ||
                       (line_state == LSNT_LS_UNKNOWN);

  // Timer control; a start register write beats everything else
  assign pre_zero = (pre_cnt == '0);
  assign noise_zero = (noise_cnt == '0);
  assign load_both = start_write ||
                     (tick && !noise_class) ||
                     (tick && noise_class && pre_zero && noise_zero);
  // No reload on a change between noise-class states: only the terms above load
  assign pre_reload = !load_both && tick && noise_class && pre_zero;
  assign noise_dec = pre_reload;
  assign pre_dec = !load_both && tick && noise_class && !pre_zero;

  // Prescale counter
  lsnt_down_counter #(
    .WIDTH(PRE_W)
  ) u_prescale_cnt (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .load(load_both || pre_reload),
    .load_val(prescale_start_d),
    .dec(pre_dec),
    .count_q(pre_cnt)
  );

  // Noise counter, zero after reset
  lsnt_down_counter #(
    .WIDTH(NOISE_W)
  ) u_noise_cnt (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .load(load_both),
    .load_val(noise_start_d),
    .dec(noise_dec),
    .count_q(noise_cnt)
  );

  assign noise_count = noise_cnt;
  assign prescale_count = pre_cnt;

  // Expiry is seen on the tick where both counters stand at zero
  assign flag_set = tick && noise_class && pre_zero && noise_zero;

  // Noise expired flag; set beats a clearing write in the same cycle
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      noise_flag_q <= NOISE_FLAG_RESET;
    end
    else if (flag_set)
    begin
      noise_flag_q <= 1'b1;
    end
    else if (flag_clear)
    begin
      noise_flag_q <= 1'b0;
    end
  end
  assign noise_expired_flag = noise_flag_q;

  // Condition flags A with the local noise expired flag in its slot
  always_comb
  begin
    flags_a_eff = receive_condition_flags_a;
    flags_a_eff[NOISE_FLAG_BIT] = noise_flag_q;
  end

  // Summary bits for the interrupt condition register
  lsnt_mask_summary #(
    .WIDTH(DATA_W)
  ) u_summary_a (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .flags(flags_a_eff),
    .mask(mask_a_q),
    .summary_q(receive_summary_a)
  );

  lsnt_mask_summary #(
    .WIDTH(DATA_W)
  ) u_summary_b (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .flags(receive_condition_flags_b),
    .mask(mask_b_q),
    .summary_q(receive_summary_b)
  );

  // Checks on the behaviour above
  default clocking cb_chk @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  AST_SUMMARY_A: assert property (
    ##1 (receive_summary_a == $past(|(flags_a_eff & mask_a_q))))
    else $error("summary A does not follow masked flags A");

  AST_SUMMARY_B: assert property (
    (|(receive_condition_flags_b & mask_b_q)) |=> receive_summary_b)
    else $error("summary B missed an enabled flag B");

  AST_MASK_RESET: assert property (disable iff (1'b0)
    $rose(reset_n) |-> (mask_a_q == MASK_RESET && mask_b_q == MASK_RESET))
    else $error("masks not clear after reset");

  AST_MASK_A_WRITE: assert property (
    wr_mask_a |=> (mask_a_q == $past(cb_wdata)))
    else $error("mask A write not stored");

  AST_MASK_B_READ: assert property (
    (cb_rd && cb_addr == ADDR_MASK_B) |=> (cb_rdata == $past(mask_b_q)))
    else $error("mask B readback wrong");

  AST_PRESCALE_STEP: assert property (
    pre_dec |=> (pre_cnt == $past(pre_cnt) - PRE_W'(1) && noise_cnt == $past(noise_cnt)))
    else $error("prescale step wrong");

  AST_BOTH_ZERO_RELOAD: assert property (
    (tick && noise_class && pre_zero && noise_zero && !start_write)
      |=> (pre_cnt == $past(prescale_start_q) && noise_cnt == $past(noise_start_q)))
    else $error("counters not reloaded at expiry");

  AST_QUIET_HOLD: assert property (
    (tick && !noise_class) |=> (pre_cnt == prescale_start_q && noise_cnt == noise_start_q))
    else $error("counters not held in quiet-class state");

  AST_WRITE_LOAD: assert property (
    start_write |=> (pre_cnt == prescale_start_q && noise_cnt == noise_start_q))
    else $error("start write did not load counters");

  AST_PRESCALE_WRAP: assert property (
    pre_reload |=> (pre_cnt == $past(prescale_start_q) && noise_cnt == $past(noise_cnt) - NOISE_W'(1)))
    else $error("prescale wrap did not decrement noise counter");

  AST_FLAG_SET: assert property (
    flag_set |=> noise_flag_q)
    else $error("expiry did not set flag");

  AST_NT_UPPER_ZERO: assert property (
    (cb_rd && cb_addr == ADDR_NOISE_START) |=> (cb_rdata[DATA_W-1] == 1'b0))
    else $error("noise start bit 7 not zero");

  AST_FLAG_HOLD: assert property (
    (noise_flag_q && !flag_clear) |=> noise_flag_q)
    else $error("flag dropped without clearing write");

  AST_FLAG_AT_RESET: assert property (disable iff (1'b0)
    $rose(reset_n) |-> noise_flag_q)
    else $error("flag not set out of reset");

  AST_TICK_PERIOD: assert property (
    tick |=> (!tick [*7]) ##1 tick)
    else $error("pair tick period not eight cycles");

  AST_IDLE_STABLE: assert property (
    (!tick && !start_write) |=> ($stable(pre_cnt) && $stable(noise_cnt)))
    else $error("counters moved between ticks");

endmodule

// *** testbench/lsnt_sm_model.sv ***
// Station management model that drives the control bus of the block
`timescale 1ns/10ps
module lsnt_sm_model (
  input wire logic clk_sys, // System clock
  output logic [lsnt_pkg::ADDR_W-1:0] cb_addr, // Register address
  output logic [lsnt_pkg::DATA_W-1:0] cb_wdata, // Write data
  output logic cb_wr, // Write strobe
  output logic cb_rd, // Read strobe
  input wire logic [lsnt_pkg::DATA_W-1:0] cb_rdata // Read data
);
  import lsnt_pkg::*;

  // Start values that software should use for about 1.3 ms of noise
  localparam logic [DATA_W-1:0] REC_NOISE = 8'h40;
  localparam logic [DATA_W-1:0] REC_PRESCALE = 8'hf9;

  // Idle bus at time zero
  initial
  begin
    cb_addr = 5'h00;
    cb_wdata = 8'h00;
    cb_wr = 1'b0;
    cb_rd = 1'b0;
  end

  // One write cycle; data is scrambled once the strobe drops
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge clk_sys);
    cb_addr = a;
    cb_wdata = d;
    cb_wr = 1'b1;
    @(negedge clk_sys);
    cb_wr = 1'b0;
    cb_wdata = ~d;
  endtask

  // One read cycle; data is valid the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(negedge clk_sys);
    cb_addr = a;
    cb_rd = 1'b1;
    @(negedge clk_sys);
    cb_rd = 1'b0;
    d = cb_rdata;
  endtask
endmodule

// *** testbench/tb_top.sv ***
// Self-checking testbench for the event masks and noise timer
`timescale 1ns/10ps
module tb_top;
  import lsnt_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [ADDR_W-1:0] cb_addr;
  logic [DATA_W-1:0] cb_wdata;
  logic cb_wr;
  logic cb_rd;
  logic [DATA_W-1:0] cb_rdata;
  lsnt_line_e line_state = LSNT_LS_QUIET;
  logic [DATA_W-1:0] flags_a = 8'hff;
  logic [DATA_W-1:0] flags_b = 8'hff;
  logic noise_expired_flag;
  logic receive_summary_a;
  logic receive_summary_b;
  logic [NOISE_W-1:0] noise_count;
  logic [PRE_W-1:0] prescale_count;
  logic pair_tick;
  logic [DATA_W-1:0] rd_v;
  int fails = 0;
  int n_checks = 0;

  // 100 MHz clock
  always #5 clk_sys = ~clk_sys;

  lsnt_top dut (.clk_sys(clk_sys), .reset_n(reset_n), .cb_addr(cb_addr), .cb_wdata(cb_wdata),
    .cb_wr(cb_wr), .cb_rd(cb_rd), .cb_rdata(cb_rdata), .line_state(line_state),
    .receive_condition_flags_a(flags_a), .receive_condition_flags_b(flags_b),
    .noise_expired_flag(noise_expired_flag), .receive_summary_a(receive_summary_a),
    .receive_summary_b(receive_summary_b), .noise_count(noise_count),
    .prescale_count(prescale_count), .pair_tick(pair_tick));

  lsnt_sm_model sm (.clk_sys(clk_sys), .cb_addr(cb_addr), .cb_wdata(cb_wdata), .cb_wr(cb_wr),
    .cb_rd(cb_rd), .cb_rdata(cb_rdata));

  // Compare byte results
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Compare single flags
  task automatic chk1(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Mask registers after reset, with every flag raised
  task automatic t_reset();
    sm.rd(ADDR_MASK_A, rd_v);
    chk8(rd_v, 8'h00, "mask A reset");
    sm.rd(ADDR_MASK_B, rd_v);
    chk8(rd_v, 8'h00, "mask B reset");
    chk1(receive_summary_a, 1'b0, "summary A masked");
    chk1(receive_summary_b, 1'b0, "summary B masked");
    $display("Test reset done");
  endtask

  // Readback of all registers, width limits and unmapped space
  task automatic t_regs();
    logic [ADDR_W-1:0] a [4] = '{ADDR_MASK_A, ADDR_MASK_B, ADDR_NOISE_START, ADDR_PRESCALE_START};
    logic [7:0] e [4] = '{8'hff, 8'hff, 8'h7f, 8'hff};
    foreach (a[i])
    begin
      sm.wr(a[i], 8'hff);
      sm.rd(a[i], rd_v);
      chk8(rd_v, e[i], "register readback");
    end
    chk8({1'b0, noise_count}, 8'h7f, "noise load width");
    chk8(prescale_count, 8'hff, "prescale load width");
    sm.wr(ADDR_NOISE_START, sm.REC_NOISE);
    sm.wr(ADDR_PRESCALE_START, sm.REC_PRESCALE);
    sm.rd(ADDR_NOISE_START, rd_v);
    chk8(rd_v, 8'h40, "recommended noise start");
    sm.rd(ADDR_PRESCALE_START, rd_v);
    chk8(rd_v, 8'hf9, "recommended prescale start");
    sm.wr(5'h1f, 8'h55);
    sm.rd(5'h1f, rd_v);
    chk8(rd_v, 8'h00, "unmapped read");
    sm.wr(ADDR_MASK_A, 8'h00);
    sm.wr(ADDR_MASK_B, 8'h00);
    $display("Test registers done");
  endtask

  // Walk one flag and one mask bit through both groups
  task automatic t_masks();
    logic [7:0] m;
    for (int i = 0; i < 8; i++)
    begin
      m = 8'(1 << i);
      flags_a = m;
      flags_b = m;
      sm.wr(ADDR_MASK_A, m);
      sm.wr(ADDR_MASK_B, m);
      repeat (2) @(negedge clk_sys);
      chk1(receive_summary_a, (i != 5), "summary A enabled");
      chk1(receive_summary_b, 1'b1, "summary B enabled");
      sm.wr(ADDR_MASK_A, ~m);
      sm.wr(ADDR_MASK_B, ~m);
      repeat (2) @(negedge clk_sys);
      chk1(receive_summary_a, 1'b0, "summary A other bits");
      chk1(receive_summary_b, 1'b0, "summary B other bits");
    end
    flags_a = 8'h00;
    flags_b = 8'h00;
    $display("Test masks done");
  endtask

  // Every quiet-class state reloads and holds part-run counters
  task automatic t_quiet();
    lsnt_line_e q [5] = '{LSNT_LS_QUIET, LSNT_LS_HALT, LSNT_LS_MASTER, LSNT_LS_IDLE, LSNT_LS_NOSIG};
    sm.wr(ADDR_NOISE_START, 8'h03);
    sm.wr(ADDR_PRESCALE_START, 8'h02);
    foreach (q[i])
    begin
      line_state = LSNT_LS_NOISE;
      repeat (12) @(negedge clk_sys);
      line_state = q[i];
      repeat (20) @(negedge clk_sys);
      chk8({1'b0, noise_count}, 8'h03, "held noise count");
      chk8(prescale_count, 8'h02, "held prescale count");
    end
    $display("Test quiet hold done");
  endtask

  // A start write in mid-count loads both counters
  task automatic t_wload();
    sm.wr(ADDR_NOISE_START, 8'h05);
    line_state = LSNT_LS_ACTIVE;
    repeat (30) @(negedge clk_sys);
    sm.wr(ADDR_PRESCALE_START, 8'h04);
    chk8({1'b0, noise_count}, 8'h05, "noise load on write");
    chk8(prescale_count, 8'h04, "prescale load on write");
    repeat (20) @(negedge clk_sys);
    sm.wr(ADDR_NOISE_START, 8'h06);
    chk8({1'b0, noise_count}, 8'h06, "noise load second write");
    chk8(prescale_count, 8'h04, "prescale load second write");
    line_state = LSNT_LS_QUIET;
    $display("Test write load done");
  endtask

  // Count ticks in noise-class states until both counters are zero
  task automatic run_to_zero(output int ticks);
    lsnt_line_e c [3] = '{LSNT_LS_NOISE, LSNT_LS_ACTIVE, LSNT_LS_UNKNOWN};
    ticks = 0;
    line_state = LSNT_LS_NOISE;
    repeat (3000)
    begin
      if (noise_count === 7'h00 && prescale_count === 8'h00)
        break;
      if (pair_tick === 1'b1)
      begin
        ticks++;
        line_state = c[ticks % 3];
      end
      @(negedge clk_sys);
    end
  endtask

  // Expiry time, flag and reload from a fresh load
  task automatic t_expiry(input logic [7:0] n, input logic [7:0] p);
    int ticks;
    line_state = LSNT_LS_QUIET;
    sm.wr(ADDR_NOISE_START, n);
    sm.wr(ADDR_PRESCALE_START, p);
    chk1(noise_expired_flag, 1'b0, "flag cleared by write");
    run_to_zero(ticks);
    chk8(8'(ticks), 8'((p + 1) * n + p), "ticks to zero");
    repeat (9)
    begin
      if (pair_tick === 1'b1)
        break;
      @(negedge clk_sys);
    end
    repeat (2) @(negedge clk_sys);
    chk1(noise_expired_flag, 1'b1, "flag on expiry");
    chk8({1'b0, noise_count}, n, "noise reload");
    chk8(prescale_count, p, "prescale reload");
    line_state = LSNT_LS_QUIET;
    $display("Test expiry %h %h done", n, p);
  endtask

  // Flag survives zero writes and feeds summary A through its mask
  task automatic t_flag();
    sm.wr(ADDR_MASK_A, 8'h20);
    sm.wr(ADDR_NOISE_START, 8'h80);
    sm.wr(ADDR_PRESCALE_START, 8'h00);
    repeat (20) @(negedge clk_sys);
    chk1(noise_expired_flag, 1'b1, "flag kept on zero write");
    chk1(receive_summary_a, 1'b1, "summary A from flag");
    sm.rd(ADDR_NOISE_START, rd_v);
    chk8(rd_v, 8'h00, "bit 7 ignored");
    sm.wr(ADDR_PRESCALE_START, 8'h01);
    chk1(noise_expired_flag, 1'b0, "flag cleared by one");
    repeat (2) @(negedge clk_sys);
    chk1(receive_summary_a, 1'b0, "summary A after clear");
    $display("Test flag done");
  endtask

  // Main sequence
  initial
  begin
    repeat (10) @(negedge clk_sys);
    chk1(noise_expired_flag, 1'b1, "flag in reset");
    chk8({1'b0, noise_count}, 8'h00, "count in reset");
    reset_n = 1'b1;
    t_reset();
    t_regs();
    t_masks();
    t_quiet();
    t_wload();
    t_expiry(8'h01, 8'h01);
    t_expiry(8'h02, 8'h03);
    t_expiry(8'h03, 8'h05);
    t_flag();
    complete_run();
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    #200000;
    fails++;
    $display("ERROR at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule
